// file: hdl/fpr_top.sv
// pause / hardware restart / write latch / array protection control
// What this block does
// - role bit 0, quad off: shared pin is an active-low pause input
// - role bit 1, quad off: shared pin is an active-low restart input
// - quad on: no pause, no restart, shared pin is data line 3
// - pause halts serial traffic, running write or erase carries on
// - pause starts on pin fall with clock low, else at clock low
// - pause ends on pin rise with clock low, else at clock low
// - paused: serial output released, input and clock ignored
// - chip select rising while paused abandons the transaction
// - restart pin low at least 1 us restarts the device
// - after restart: standby, volatile bits at power-on values
// - write permit command sets the write latch
// - latch cleared by reset, revoke, status write, program, erases
// - protected region stays readable, never programmed or erased
// - protect pin low blocks writes to region select and lock bits
// - deep power-down ignores all but release and software reset
// - invert 0, bit4 0: fractions 1/64..1/2, bit3 picks bottom
// - invert 0, bit4 1: 4KB..32KB at top, bit3 picks bottom
// - invert 0: low bits 000 protect nothing, 111 everything
// - invert 1 protects the exact complement
// - quad off: protect and shared pins are control inputs
// - latch clear: status write, program and erase refused
// assumes a host that keeps the serial clock still outside frames
`timescale 1ns/1ps
module fpr_top
  import fpr_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_PERMIT = 8'h06,
  parameter logic [7:0] OP_WRITE_REVOKE = 8'h04,
  parameter logic [7:0] OP_STATUS_WRITE = 8'h01,
  parameter logic [7:0] OP_PAGE_PROGRAM = 8'h02,
  parameter logic [7:0] OP_SECTOR_WIPE  = 8'h20,
  parameter logic [7:0] OP_HALF_WIPE    = 8'h52,
  parameter logic [7:0] OP_BLOCK_WIPE   = 8'hD8,
  parameter logic [7:0] OP_CHIP_WIPE    = 8'hC7,
  parameter logic [7:0] OP_DEEP_PD      = 8'hB9,
  parameter logic [7:0] OP_RELEASE_PD   = 8'hAB
)
(
  input  wire logic      clk_i,
  input  wire logic      nrst_i,
  input  wire logic      sclk_i,
  input  wire logic      cs_n_i,
  input  wire logic      si_i,
  input  wire logic      mp_pin_i,
  input  wire logic      wp_pin_i,
  input  wire logic      so_drive_i,
  output logic           so_oe_o,
  output logic           paused_o,
  output logic           busy_o,
  output logic           deep_power_down_o,
  output logic           write_latch_o,
  output logic           mp_is_data_o,
  output logic           wp_is_data_o,
  output fpr_status_type status_o,
  output fpr_array_op_type array_op_o
);
  localparam int NSYNC = 3;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_meta;
  logic [NSYNC-1:0] pin_sync;
  logic             cs_s;
  logic             mp_s;
  logic             wp_s;
  logic             cs_q;
  fpr_state_type    state;
  fpr_state_type    next_state;
  fpr_status_type   status;
  fpr_frame_type    link_frame;
  fpr_frame_type    frame_q;
  fpr_array_op_type array_op;
  logic             cmd_valid;
  logic             write_latch;
  logic             next_latch;
  logic             reset_armed;
  logic             paused;
  logic [7:0]       busy_cnt;
  logic [7:0]       rst_cnt;

  // chip select, shared and protect pins pass two flops before system-clock use here
  assign pin_raw = {cs_n_i, mp_pin_i, wp_pin_i};
  generate
    for (genvar g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
        begin
          pin_meta[g] <= 1'b1;
          pin_sync[g] <= 1'b1;
        end
        else
        begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate
  assign cs_s = pin_sync[2];
  assign mp_s = pin_sync[1];
  assign wp_s = pin_sync[0];

  // role of the shared pin and of the protect pin
  logic hold_fn;
  logic restart_fn;
  logic paused_s;
  logic wp_block;
  assign hold_fn    = ~status.pin_role & ~status.quad_io_enable;
  assign restart_fn = status.pin_role & ~status.quad_io_enable;
  assign paused_s   = hold_fn & ~mp_s;
  assign wp_block   = ~status.quad_io_enable & ~wp_s;

  // frame end seen by the system clock; link words are still by now
  logic frame_end;
  logic restart_low;
  logic restart_fire;
  assign frame_end    = cs_s & ~cs_q;
  assign restart_low  = restart_fn & ~mp_s;
  assign restart_fire = restart_low & (rst_cnt == RESTART_FIRE_AT);

  // opcode decode
  logic [7:0] op;
  logic [5:0] nb;
  logic       op_is_permit;
  logic       op_is_revoke;
  logic       op_is_status;
  logic       op_is_program;
  logic       op_is_sector;
  logic       op_is_half;
  logic       op_is_block;
  logic       op_is_chip;
  logic       op_is_dpd;
  logic       op_is_release;
  logic       op_is_arm;
  logic       op_is_swreset;
  logic       is_array;
  logic       is_write;
  assign op            = frame_q.opcode;
  assign nb            = frame_q.nbits;
  assign op_is_permit  = op == OP_WRITE_PERMIT;
  assign op_is_revoke  = op == OP_WRITE_REVOKE;
  assign op_is_status  = op == OP_STATUS_WRITE;
  assign op_is_program = op == OP_PAGE_PROGRAM;
  assign op_is_sector  = op == OP_SECTOR_WIPE;
  assign op_is_half    = op == OP_HALF_WIPE;
  assign op_is_block   = op == OP_BLOCK_WIPE;
  assign op_is_chip    = op == OP_CHIP_WIPE;
  assign op_is_dpd     = op == OP_DEEP_PD;
  assign op_is_release = op == OP_RELEASE_PD;
  assign op_is_arm     = op == SW_RESET_ARM_OP;
  assign op_is_swreset = op == SW_RESET_OP;
  assign is_array      = op_is_program | op_is_sector | op_is_half |
                         op_is_block | op_is_chip;
  assign is_write      = is_array | op_is_status;

  // data bits left-aligned so a short status write lands in byte one
  logic [5:0]  data_bits;
  logic [5:0]  align;
  logic [23:0] data_al;
  assign data_bits = (nb > OPCODE_BITS) ? nb - OPCODE_BITS : 6'h00;
  assign align     = DATA_BITS - data_bits;
  assign data_al   = frame_q.data << align;

  // address range touched by the operation
  logic [23:0]     op_span;
  logic [23:0]     first_addr;
  logic [23:0]     last_addr;
  fpr_op_kind_type op_kind;
  assign op_span    = op_is_sector ? SECTOR_SPAN :
                      op_is_half ? HALF_BLOCK_SPAN :
                      op_is_block ? BLOCK_SPAN : ADDR_ZERO;
  assign first_addr = op_is_chip ? ADDR_ZERO : data_al & ~op_span;
  assign last_addr  = op_is_chip ? ARRAY_LAST : first_addr | op_span;
  assign op_kind    = op_is_chip ? KIND_CHIP :
                      (op_is_block | op_is_half) ? KIND_BLOCK :
                      op_is_sector ? KIND_SECTOR : KIND_PROGRAM;

  // protected regions sit at one end, so checking both ends suffices
  logic prot_first;
  logic prot_last;
  logic prot_hit;
  fpr_region_check u_check_first (
    .region_select_bits_i (status.region_select_bits),
    .region_invert_i      (status.region_invert),
    .addr_i               (first_addr),
    .protected_o          (prot_first)
  );
  fpr_region_check u_check_last (
    .region_select_bits_i (status.region_select_bits),
    .region_invert_i      (status.region_invert),
    .addr_i               (last_addr),
    .protected_o          (prot_last)
  );
  assign prot_hit = prot_first | prot_last;

  // acceptance of commands
  logic idle;
  logic accept_write;
  logic array_go;
  logic sr_go;
  logic sw_reset;
  assign idle         = state == ST_IDLE;           // dpd not idle
  assign accept_write = cmd_valid & is_write & idle & write_latch;
  assign array_go     = accept_write & is_array & ~prot_hit &
                        (op_is_chip | (nb == FRAME_BITS));
  assign sr_go        = accept_write & op_is_status & (nb >= SR1_END);
  assign sw_reset     = cmd_valid & op_is_swreset & reset_armed;

  // serial side; pause enable is a level crossing into that domain
  fpr_link_shift u_link (
    .sclk_i     (sclk_i),
    .cs_n_i     (cs_n_i),
    .si_i       (si_i),
    .mp_pin_i   (mp_pin_i),
    .hold_en_i  (hold_fn),
    .so_drive_i (so_drive_i),
    .so_oe_o    (so_oe_o),
    .frame_o    (link_frame)
  );

  // frame hand-over; a paused or restarting end is dropped
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cs_q      <= 1'b1;
      cmd_valid <= 1'b0;
      frame_q   <= '0;
      paused    <= 1'b0;
    end
    else
    begin
      cs_q      <= cs_s;
      cmd_valid <= frame_end & ~paused_s & ~restart_low &
                   (link_frame.nbits >= OPCODE_BITS);
      if (frame_end)
        frame_q <= link_frame;
      paused    <= paused_s & ~cs_s;
    end
  end

  // control state; busy runs on regardless of a pause
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (array_go | sr_go)
          next_state = ST_BUSY;
        else if (cmd_valid & op_is_dpd)
          next_state = ST_DEEP_PD;
      ST_BUSY:
        if (busy_cnt == BUSY_LAST)
          next_state = ST_IDLE;
      ST_DEEP_PD:
        if (cmd_valid & op_is_release)
          next_state = ST_IDLE;
      ST_RESTART:
        if (mp_s)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    if (sw_reset & (state != ST_BUSY))
      next_state = ST_IDLE;
    if (restart_fire)
      next_state = ST_RESTART;
  end

  // write latch: clears outrank a set, restart outranks all
  always_comb
  begin
    next_latch = write_latch;
    if (idle & cmd_valid & op_is_permit)
      next_latch = 1'b1;
    if (idle & cmd_valid & op_is_revoke)
      next_latch = 1'b0;
    if (accept_write)
      next_latch = 1'b0;
    if (sw_reset | restart_fire)
      next_latch = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state       <= ST_IDLE;
      write_latch <= 1'b0;
      reset_armed <= 1'b0;
      busy_cnt    <= CNT_ZERO;
      rst_cnt     <= CNT_ZERO;
    end
    else
    begin
      state       <= next_state;
      write_latch <= next_latch;
      if (restart_fire)
        reset_armed <= 1'b0;
      else if (cmd_valid)
        reset_armed <= op_is_arm;
      if ((next_state == ST_BUSY) && (state != ST_BUSY))
        busy_cnt <= BUSY_CYC;
      else if (state == ST_BUSY)
        busy_cnt <= busy_cnt - 8'h01;
      if (!restart_low)
        rst_cnt <= CNT_ZERO;
      else if (rst_cnt != RESTART_DONE)
        rst_cnt <= rst_cnt + 8'h01;
    end
  end

  // status bits; hardware restart leaves these kept bits alone
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      status <= STATUS_RST;
    else if (sr_go)
    begin
      if (!wp_block)
      begin
        status.status_lock_lo     <= data_al[LOCK_LO_POS];
        status.region_select_bits <= data_al[REGION_LSB +: 5];
      end
      if (nb >= SR2_END)
      begin
        status.region_invert  <= data_al[INVERT_POS];
        status.quad_io_enable <= data_al[QUAD_POS];
        if (!wp_block)
          status.status_lock_hi <= data_al[LOCK_HI_POS];
      end
      if (nb >= SR3_END)
        status.pin_role <= data_al[ROLE_POS];
    end
  end

  // granted array operation, one-cycle strobe to the array engine
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      array_op <= '0;
    else
    begin
      array_op.valid <= array_go;
      if (array_go)
      begin
        array_op.kind  <= op_kind;
        array_op.first <= first_addr;
        array_op.last  <= last_addr;
      end
    end
  end

  // outputs
  assign paused_o          = paused;
  assign busy_o            = state == ST_BUSY;
  assign deep_power_down_o = state == ST_DEEP_PD;
  assign write_latch_o     = write_latch;
  assign mp_is_data_o      = status.quad_io_enable;
  assign wp_is_data_o      = status.quad_io_enable;
  assign status_o          = status;
  assign array_op_o        = array_op;

  // checks
  chk_latch_set_cmd:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmd_valid && idle && op_is_permit && !restart_fire |=> write_latch)
  else $error("permit did not set the write latch");

  chk_latch_drop_cmd:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmd_valid && idle && write_latch && (op_is_revoke || is_write)
    |=> !write_latch)
  else $error("write latch survived a clearing command");

  chk_no_latch_op:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    array_op.valid |-> $past(write_latch, 2) && $past(idle))
  else $error("array operation granted without the write latch");

  chk_protect_refuse:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    accept_write && is_array && prot_hit
    |=> !array_op.valid && state != ST_BUSY && !write_latch)
  else $error("protected target was granted");

  chk_wp_blocks_bits:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    sr_go && wp_block |=> $stable(status.region_select_bits) &&
    $stable(status.status_lock_lo) && $stable(status.status_lock_hi))
  else $error("protect pin low but region or lock bits changed");

  chk_dpd_ignores:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == ST_DEEP_PD && cmd_valid && !op_is_release &&
    !op_is_swreset && !restart_fire
    |=> state == ST_DEEP_PD && $stable(write_latch))
  else $error("command acted during deep power-down");

  chk_quad_pin_data:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    status.quad_io_enable && !mp_s |=> !paused_o && !restart_fire)
  else $error("pause or restart acted with quad enabled");

  chk_pause_abort:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    frame_end && paused_s |=> !cmd_valid ##1 $stable(write_latch))
  else $error("frame ended in pause was executed");

  chk_restart_clean:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    restart_fire |=> state == ST_RESTART && !write_latch &&
    !reset_armed ##1 !busy_o && !deep_power_down_o)
  else $error("restart left volatile state behind");

  chk_restart_width:
  assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(state == ST_RESTART) |-> $past(restart_low, 10) &&
    $past(restart_low, 2))
  else $error("restart taken before the minimum pulse");
endmodule

// file: hdl/fpr_pkg.sv
// shared constants and types of the pause/restart/write-protect block
// assumes a 10 MHz system clock and a 24-bit array address
package fpr_pkg;

  // timing, system clock
  localparam int CLK_PERIOD_NS        = 100;
  localparam int RESTART_PULSE_MIN_NS = 1000;
  localparam int RESTART_PULSE_CYC    =
    (RESTART_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESTART_FIRE_AT = 8'(RESTART_PULSE_CYC - 1);
  localparam logic [7:0] RESTART_DONE    = 8'(RESTART_PULSE_CYC);
  localparam logic [7:0] BUSY_CYC        = 8'h40;
  localparam logic [7:0] BUSY_LAST       = 8'h01;
  localparam logic [7:0] CNT_ZERO        = 8'h00;

  // frame layout on the serial side
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] FRAME_BITS  = 6'h20;
  localparam logic [5:0] DATA_BITS   = 6'h18;
  localparam logic [5:0] SR1_END     = 6'h10;
  localparam logic [5:0] SR2_END     = 6'h18;
  localparam logic [5:0] SR3_END     = 6'h20;

  // software reset pair
  localparam logic [7:0] SW_RESET_ARM_OP = 8'h66;
  localparam logic [7:0] SW_RESET_OP     = 8'h99;

  // status field positions inside the left-aligned data word
  localparam int LOCK_LO_POS = 23;
  localparam int REGION_LSB  = 18;
  localparam int INVERT_POS  = 14;
  localparam int QUAD_POS    = 9;
  localparam int LOCK_HI_POS = 8;
  localparam int ROLE_POS    = 7;

  // region decode
  localparam logic [4:0] FRAC_SHIFT_BASE  = 5'h11;
  localparam logic [4:0] SMALL_SHIFT_BASE = 5'h0B;
  localparam logic [4:0] SMALL_SHIFT_CAP  = 5'h0F;
  localparam logic [2:0] REGION_NONE      = 3'h0;
  localparam logic [2:0] REGION_ALL       = 3'h7;
  localparam logic [2:0] SMALL_CAP_FROM   = 3'h4;

  // address spans of the array operations
  localparam logic [23:0] ADDR_ZERO       = 24'h000000;
  localparam logic [23:0] SECTOR_SPAN     = 24'h000FFF;
  localparam logic [23:0] HALF_BLOCK_SPAN = 24'h007FFF;
  localparam logic [23:0] BLOCK_SPAN      = 24'h00FFFF;
  localparam logic [23:0] ARRAY_LAST      = 24'hFFFFFF;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DEEP_PD, ST_RESTART}
    fpr_state_type;
  typedef enum logic [1:0] {KIND_PROGRAM, KIND_SECTOR, KIND_BLOCK,
    KIND_CHIP} fpr_op_kind_type;

  typedef struct packed {
    logic       status_lock_hi;
    logic       status_lock_lo;
    logic       region_invert;
    logic [4:0] region_select_bits;
    logic       quad_io_enable;
    logic       pin_role;
  } fpr_status_type;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] data;
    logic [5:0]  nbits;
  } fpr_frame_type;

  typedef struct packed {
    logic            valid;
    fpr_op_kind_type kind;
    logic [23:0]     first;
    logic [23:0]     last;
  } fpr_array_op_type;

  localparam fpr_status_type STATUS_RST = '0;

endpackage

// file: hdl/fpr_region_check.sv
// protected-address decode for one array address
// assumes quasi-static protect settings from the status bits
`timescale 1ns/1ps
module fpr_region_check
  import fpr_pkg::*;
(
  input  wire logic [4:0]  region_select_bits_i,
  input  wire logic        region_invert_i,
  input  wire logic [23:0] addr_i,
  output logic             protected_o
);
  logic [2:0]  low_bits;
  logic [4:0]  shift;
  logic [23:0] end_bits;
  logic        in_region;
  logic        base_hit;

  // size of the region as a power of two, fraction or small block
  assign low_bits = region_select_bits_i[2:0];
  assign shift    = !region_select_bits_i[4] ?
                    FRAC_SHIFT_BASE + {2'b00, low_bits} :
                    (low_bits >= SMALL_CAP_FROM) ? SMALL_SHIFT_CAP :
                    SMALL_SHIFT_BASE + {2'b00, low_bits};
  // bit 3 picks the bottom end, else the top end of the array
  assign end_bits  = region_select_bits_i[3] ? addr_i : ~addr_i;
  assign in_region = (end_bits >> shift) == ADDR_ZERO;
  assign base_hit  = (low_bits == REGION_ALL) ? 1'b1 :
                     (low_bits == REGION_NONE) ? 1'b0 :
                     in_region;
  // invert protects exactly the complement
  assign protected_o = base_hit ^ region_invert_i;
endmodule

// file: hdl/fpr_link_shift.sv
// serial-clock side: collects opcode and up to 24 data bits per frame
// assumes the host keeps the serial clock still while chip select is high
`timescale 1ns/1ps
module fpr_link_shift
  import fpr_pkg::*;
(
  input  wire logic    sclk_i,
  input  wire logic    cs_n_i,
  input  wire logic    si_i,
  input  wire logic    mp_pin_i,
  input  wire logic    hold_en_i,
  input  wire logic    so_drive_i,
  output logic         so_oe_o,
  output fpr_frame_type frame_o
);
  logic        hold_meta;
  logic        hold_en_s;
  logic        fresh;
  logic        held;
  logic [5:0]  count;
  logic [7:0]  opcode;
  logic [23:0] data;
  logic [5:0]  nbits;

  // pin level at a rising edge already honours the low-clock deferral
  assign held  = hold_en_s & ~mp_pin_i;
  assign count = fresh ? 6'h00 : nbits;

  // pause enable crosses in; settles two edges into a new setting
  always_ff @(posedge sclk_i)
  begin
    hold_meta <= hold_en_i;
    hold_en_s <= hold_meta;
  end

  // chip select high marks the next edge as a frame start
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
      fresh <= 1'b1;
    else if (!held)
      fresh <= 1'b0;
  end

  // shifting stops on every paused edge, clock and input ignored
  always_ff @(posedge sclk_i)
  begin
    if (!held)
    begin
      nbits <= (count < FRAME_BITS) ? count + 6'h01 : count;
      if (count < OPCODE_BITS)
        opcode <= {opcode[6:0], si_i};
      else if (count < FRAME_BITS)
        data <= {data[22:0], si_i};
    end
  end

  assign frame_o = '{opcode: opcode, data: data, nbits: nbits};
  // serial output released at once while paused
  assign so_oe_o = so_drive_i & ~cs_n_i & ~held;
endmodule

// file: dv/fpr_host.sv
// host flash controller model: frames, pause and restart pulses
// assumes the flash samples data on rising serial clock edges
`timescale 1ns/1ps
module fpr_host (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      mp_pin_o,
  output logic      wp_pin_o
);
  // idle levels; serial clock stands still outside frames
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    si_o = 1'b0;
    mp_pin_o = 1'b1;
    wp_pin_o = 1'b1;
    // a real rising edge, so the link side sees a frame start
    #1 cs_n_o = 1'b1;
  end
  // one frame msb first at 160 ns per bit; h >= 0 pauses there
  // cut 0: pause there, clock a stray edge, then resume the frame
  task automatic send(input logic [31:0] w, input int n, input int h,
                      input bit cut = 1'b1);
    int i;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (i = 0; i < n; i++)
    begin
      if (i == h)
      begin
        mp_pin_o = 1'b0;
        if (cut)
        begin
          #500 cs_n_o = 1'b1; // drop the frame while paused
          #400 mp_pin_o = 1'b1;
          break;
        end
        si_o = ~w[31-i]; // a taken edge here would corrupt the frame
        #80 sclk_o = 1'b1;
        #80 sclk_o = 1'b0;
        #80 mp_pin_o = 1'b1;
      end
      si_o = w[31-i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    cs_n_o = 1'b1;
    si_o = ~si_o; // released line shows no stale bit
    #800;
  endtask
  // restart pulse, held past the minimum width
  task automatic restart(input int ns);
    @(posedge clk_i);
    #1 mp_pin_o = 1'b0;
    #(ns) mp_pin_o = 1'b1;
    #800;
  endtask
endmodule

// file: dv/test_fpr_top.sv
// self-checking bench of the pause/restart/protect block
// assumes the host model drives every serial-side pin
`timescale 1ns/1ps
module test_fpr_top;
  import fpr_pkg::*;
  logic             clk_i, nrst_i, sclk, cs_n, si, mp, wp;
  logic             so_oe_o, paused_o, busy_o, dpd_o, wl_o, mpd_o, wpd_o;
  fpr_status_type   status_o;
  fpr_array_op_type array_op_o;
  fpr_array_op_type notes[$];
  int               mismatches, compares, seed, k;
  logic [23:0]      addr, m;
  logic [7:0]       op;
  fpr_host i_fpr_host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
    .si_o(si), .mp_pin_o(mp), .wp_pin_o(wp));
  fpr_top i_fpr_top (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .mp_pin_i(mp), .wp_pin_i(wp),
    .so_drive_i(1'b1), .so_oe_o(so_oe_o), .paused_o(paused_o),
    .busy_o(busy_o), .deep_power_down_o(dpd_o), .write_latch_o(wl_o),
    .mp_is_data_o(mpd_o), .wp_is_data_o(wpd_o), .status_o(status_o),
    .array_op_o(array_op_o));
  // 10 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string n, input logic [50:0] s, e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // bounded wait for a running write or erase to finish
  task automatic wait_idle();
    for (k = 0; k < 200 && busy_o !== 1'b0; k++)
      @(posedge clk_i);
    if (busy_o !== 1'b0)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  // permit, then the write command itself
  task automatic cmd(input logic [31:0] w, input int n);
    i_fpr_host.send(32'h06000000, 8, -1);
    i_fpr_host.send(w, n, -1);
    wait_idle();
  endtask
  // any array operation with no note pending is a refusal missed
  always @(posedge clk_i)
    if (array_op_o.valid === 1'b1)
      if (notes.size() == 0)
        check("array_op", array_op_o, '0);
      else
        check("array_op", array_op_o, notes.pop_front());
  initial
  begin
    seed = 4989;
    mismatches = 0;
    compares = 0;
    nrst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check("status", status_o, '0);
    i_fpr_host.send(32'h06000000, 8, -1);
    check("latch", wl_o, 1'b1);
    i_fpr_host.send(32'h04000000, 8, -1);
    check("latch", wl_o, 1'b0);
    i_fpr_host.send(32'h02000000, 32, -1);
    // every array operation once, all but the chip erase at a random place
    for (int j = 0; j < 5; j++)
    begin
      addr = 24'($random(seed));
      m = (j == 0) ? 24'h000FFF : (j == 1) ? 24'h00FFFF :
        (j == 2) ? 24'hFFFFFF : (j == 3) ? 24'h007FFF : 24'h000000;
      op = (j == 0) ? 8'h20 : (j == 1) ? 8'hD8 : (j == 2) ? 8'hC7 :
        (j == 3) ? 8'h52 : 8'h02;
      notes.push_back({1'b1, 2'((j < 3) ? j + 1 : (j == 3) ? 2 : 0),
        addr & ~m, addr | m});
      cmd({op, addr}, (j == 2) ? 8 : 32);
      check("latch", wl_o, 1'b0);
    end
    i_fpr_host.wp_pin_o = 1'b0;
    cmd(32'h01040000, 32);
    check("status", status_o, '0);
    i_fpr_host.wp_pin_o = 1'b1;
    cmd(32'h01040000, 32);
    check("status", status_o, 10'h004);
    cmd(32'h20FC0000, 32);
    check("latch", wl_o, 1'b0);
    notes.push_back({1'b1, KIND_SECTOR, 24'hFBF000, 24'hFBFFFF});
    cmd(32'h20FBF123, 32);
    cmd(32'h01044000, 32);
    notes.push_back({1'b1, KIND_SECTOR, 24'hFC0000, 24'hFC0FFF});
    cmd(32'h20FC0000, 32);
    cmd(32'h20FBF000, 32);
    // deep power-down ignores a revoke; software reset clears the latch
    i_fpr_host.send(32'h06000000, 8, -1);
    i_fpr_host.send(32'hB9000000, 8, -1);
    check("dpd", dpd_o, 1'b1);
    i_fpr_host.send(32'h04000000, 8, -1);
    i_fpr_host.send(32'hAB000000, 8, -1);
    check("dpd", dpd_o, 1'b0);
    check("latch", wl_o, 1'b1);
    i_fpr_host.send(32'h66000000, 8, -1);
    i_fpr_host.send(32'h99000000, 8, -1);
    check("latch", wl_o, 1'b0);
    // whole permit opcode in, then chip select rises while paused
    fork
      i_fpr_host.send(32'h06000000, 16, 8);
      begin
        @(negedge mp);
        #400;
        check("so_oe", so_oe_o, 1'b0);
        check("paused", paused_o, 1'b1);
      end
    join
    check("latch", wl_o, 1'b0);
    i_fpr_host.send(32'h06000000, 8, 4, 1'b0);
    check("latch", wl_o, 1'b1);
    cmd(32'h01000080, 32);
    i_fpr_host.send(32'h06000000, 8, -1);
    i_fpr_host.restart(1200);
    check("latch", wl_o, 1'b0);
    check("status", status_o, 10'h001);
    cmd(32'h01000280, 32);
    check("quad", {mpd_o, wpd_o}, 2'b11);
    i_fpr_host.send(32'h06000000, 8, -1);
    i_fpr_host.restart(1200);
    check("latch", wl_o, 1'b1);
    check("notes", notes.size(), 0);
    stop_test();
  end
endmodule
